// [ssi_pkg.sv]
/*
  package for the switch input shifter: widths, buffer depth, sync depth.
  assumes nothing of its surroundings.
*/
package ssi_pkg;
  // =========================================================
  // widths and counts
  localparam int SSI_WIDE_INPUTS = 16;
  localparam int SSI_NARROW_INPUTS = 8;
  localparam int SSI_SYNC_STAGES = 2;
  localparam int SSI_BUF_DEPTH = 2;
  localparam logic SSI_LINE_IDLE = 1'b1;
  localparam logic [1:0] SSI_EDGE_RISE = 2'b01;
  localparam logic [1:0] SSI_EDGE_FALL = 2'b10;
  localparam logic [1:0] SSI_SYNC_RESET = 2'b11;

  typedef enum logic [1:0] {
    SSI_IDLE = 2'b00,
    SSI_WAIT_LOAD = 2'b01,
    SSI_SHIFT = 2'b10
  } ssi_state_t;
endpackage

// [ssi_word_if.sv]
/*
  valid/ready word channel between the shifter core and its buffer.
  assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
interface ssi_word_if #(parameter int WIDTH = 16);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport source (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface

// [ssi_buffer.sv]
/*
  two-entry buffer holding captured snapshots on their way to the shift
  register; read data come from a register.
  assumes source and sink run on clk_i.
*/
`timescale 1ns/1ps
module ssi_buffer
  import ssi_pkg::*;
#(
  parameter int WIDTH = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // filling side
  ssi_word_if.sink wr,
  // draining side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  // =========================================================
  // storage
  logic [WIDTH-1:0] mem [SSI_BUF_DEPTH];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] count;
  wire push = wr.valid && wr.ready;
  wire pop = out_valid_o && out_ready_i;

  assign wr.ready = (count != 2'(SSI_BUF_DEPTH));
  assign out_valid_o = (count != 2'd0);

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= wr.data;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'd0;
    end else begin
      wr_ptr <= wr_ptr ^ push;
      rd_ptr <= rd_ptr ^ pop;
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end

  // registered read data: next word after a pop, else current head
  wire rd_sel = rd_ptr ^ pop;
  wire [WIDTH-1:0] head = push && (count == 2'd0 || (pop && count == 2'd1))
    ? wr.data : mem[rd_sel];
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      out_data_o <= '0;
    end else begin
      out_data_o <= head;
    end
  end
endmodule

// [ssi_shifter.sv]
/*
  serial switch input shifter: snapshots switch inputs on chip select
  falling, shifts them out msb first, raises an open-drain change interrupt.
  assumes serial pins are asynchronous to clk_i and slow enough (serial
  clock at most 5 MHz) to be oversampled by the 40 MHz clock.
*/
// Operation
// - a falling chip select captures all switch inputs as one snapshot.
// - that same falling chip select drops any pending interrupt.
// - with chip select low, rising serial clocks load then shift out.
// - serial data in is sampled on falling serial clock while selected.
// - interrupt rises when live inputs differ from the snapshot.
// - input count is a parameter, sixteen wide or eight narrow.
// - with interrupt enable low the interrupt pin is released.
// - the interrupt is open-drain, active low, pulling low only.
// - serial data out is driven only while selected.
// - chip select is active low and gates all serial activity.
// - first rising edge loads and shows the msb, later ones shift.
// - the interrupt clears when live inputs match the snapshot again.
// - bits shifted in reappear at serial data out for chaining.
`timescale 1ns/1ps
module ssi_shifter
  import ssi_pkg::*;
#(
  parameter int NUM_INPUTS = SSI_WIDE_INPUTS
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // switch inputs
  input wire logic [NUM_INPUTS-1:0] switch_input_i,
  // serial link
  input wire logic chip_select_n_i,
  input wire logic serial_clock_i,
  input wire logic serial_data_in_i,
  output logic serial_data_out_o,
  output logic serial_data_out_oe_o,
  // interrupt
  input wire logic int_enable_i,
  output logic int_n_o,
  output logic int_n_oe_o
);
  // =========================================================
  // input synchronisers
  logic [NUM_INPUTS-1:0] sw_meta;
  logic [NUM_INPUTS-1:0] sw_sync;
  logic [1:0] cs_meta;
  logic [1:0] sck_meta;
  logic sdi_meta;
  logic sdi_sync;
  logic en_meta;
  logic en_sync;
  logic [1:0] cs_hist;
  logic [1:0] sck_hist;

  always_ff @(posedge clk_i) begin
    sw_meta <= switch_input_i;
    sw_sync <= sw_meta;
    sdi_meta <= serial_data_in_i;
    sdi_sync <= sdi_meta;
    en_meta <= int_enable_i;
    en_sync <= en_meta;
  end

  // chip select and serial clock restart at their idle levels, so no
  // false edge is seen right after reset
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cs_meta <= SSI_SYNC_RESET;
      sck_meta <= 2'b00;
      cs_hist <= SSI_SYNC_RESET;
      sck_hist <= 2'b00;
    end else begin
      cs_meta <= {cs_meta[0], chip_select_n_i};
      sck_meta <= {sck_meta[0], serial_clock_i};
      cs_hist <= {cs_hist[0], cs_meta[1]};
      sck_hist <= {sck_hist[0], sck_meta[1]};
    end
  end

  // =========================================================
  // edge decode
  function automatic logic edge_seen(input logic [1:0] hist,
                                     input logic [1:0] code);
    return hist == code;
  endfunction

  wire cs_fall = edge_seen(cs_hist, SSI_EDGE_FALL);
  wire selected = !cs_hist[0];
  wire sck_rise = edge_seen(sck_hist, SSI_EDGE_RISE) && selected;
  wire sck_fall = edge_seen(sck_hist, SSI_EDGE_FALL) && selected;

  // =========================================================
  // snapshot and buffer
  logic [NUM_INPUTS-1:0] snapshot;
  logic snap_pending;
  logic [NUM_INPUTS-1:0] shreg;
  logic out_bit;
  logic sdi_hold;
  logic buf_valid;
  logic buf_ready;
  logic [NUM_INPUTS-1:0] buf_data;
  ssi_state_t state;
  ssi_state_t next_state;

  ssi_word_if #(.WIDTH(NUM_INPUTS)) snap_ch ();

  assign snap_ch.valid = snap_pending;
  assign snap_ch.data = snapshot;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      snapshot <= '0;
      snap_pending <= 1'b0;
    end else if (cs_fall) begin
      snapshot <= sw_sync;
      snap_pending <= 1'b1;
    end else if (snap_ch.ready) begin
      snap_pending <= 1'b0;
    end
  end

  // the buffer lets a snapshot wait for the load edge without loss
  ssi_buffer #(.WIDTH(NUM_INPUTS)) u_buffer (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .wr(snap_ch.sink),
    .out_valid_o(buf_valid),
    .out_ready_i(buf_ready),
    .out_data_o(buf_data)
  );

  // drain one word per frame at the load edge; stale words drop at deselect
  wire load_now = (state == SSI_WAIT_LOAD) && sck_rise && buf_valid;
  assign buf_ready = load_now || (!selected && buf_valid && !snap_pending);

  // =========================================================
  // frame state
  // deselect ends a frame from any state, so a cut frame never leaves
  // the shifter armed for a stray load
  always_comb begin
    next_state = state;
    unique case (state)
      SSI_IDLE: if (cs_fall) next_state = SSI_WAIT_LOAD;
      SSI_WAIT_LOAD: begin
        if (!selected) next_state = SSI_IDLE;
        else if (load_now) next_state = SSI_SHIFT;
      end
      SSI_SHIFT: if (!selected) next_state = SSI_IDLE;
      default: next_state = SSI_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state <= SSI_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // =========================================================
  // shift register
  // falling edges park serial data in until the next shift, so the
  // lowest snapshot bit is not overwritten before it leaves
  wire shift_now = (state == SSI_SHIFT) && sck_rise;
  wire sample_now = (state == SSI_SHIFT) && sck_fall;
  wire [NUM_INPUTS-1:0] shifted = {shreg[NUM_INPUTS-2:0], sdi_hold};

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      shreg <= '0;
    end else if (load_now) begin
      shreg <= buf_data;
    end else if (shift_now) begin
      shreg <= shifted;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sdi_hold <= 1'b0;
    end else if (sample_now) begin
      sdi_hold <= sdi_sync;
    end
  end

  // output bit is cleared between frames so each frame starts at 0
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      out_bit <= 1'b0;
    end else if (load_now) begin
      out_bit <= buf_data[NUM_INPUTS-1];
    end else if (shift_now) begin
      out_bit <= shreg[NUM_INPUTS-2];
    end else if (!selected) begin
      out_bit <= 1'b0;
    end
  end

  // =========================================================
  // interrupt
  // a level, not a sticky flag: a falling chip select drops it for a
  // cycle, then it follows the compare against the fresh snapshot
  logic int_active;
  wire differ = (sw_sync != snapshot);
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      int_active <= 1'b0;
    end else if (cs_fall) begin
      int_active <= 1'b0;
    end else begin
      int_active <= differ && en_sync;
    end
  end

  assign int_n_o = 1'b0;
  assign int_n_oe_o = int_active;
  assign serial_data_out_o = out_bit;
  assign serial_data_out_oe_o = selected;
endmodule

// [ssi_shifter_asserts.sv]
/* checker for ssi_shifter, watching its ports only.
   assumes clk_i oversamples the serial pins. */
`timescale 1ns/1ps
module ssi_shifter_asserts #(
  parameter int NUM_INPUTS = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // watched pins
  input wire logic [NUM_INPUTS-1:0] switch_input_i,
  input wire logic chip_select_n_i,
  input wire logic serial_clock_i,
  input wire logic serial_data_in_i,
  input wire logic serial_data_out_o,
  input wire logic serial_data_out_oe_o,
  input wire logic int_enable_i,
  input wire logic int_n_o,
  input wire logic int_n_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // =======================================
  // cycles since a cause of change
  logic [3:0] quiet;
  logic [3:0] since_rise;
  always_ff @(posedge clk_i) begin
    if (reset_i || $changed(switch_input_i) || $rose(int_enable_i)
        || $fell(chip_select_n_i))
      quiet <= 4'h0;
    else if (quiet != 4'hf)
      quiet <= quiet + 4'h1;
    if (reset_i || $rose(serial_clock_i))
      since_rise <= 4'h0;
    else if (since_rise != 4'hf)
      since_rise <= since_rise + 4'h1;
  end
  a_oe_off_idle: assert property (
    chip_select_n_i [*8] |-> !serial_data_out_oe_o) else $error("oe idle");
  a_oe_on_sel: assert property (
    !chip_select_n_i [*8] |-> serial_data_out_oe_o) else $error("oe sel");
  a_sdo_release: assert property (
    $rose(chip_select_n_i) |-> ##[2:6] !serial_data_out_oe_o)
    else $error("oe release");
  a_out_after_rise: assert property (
    serial_data_out_oe_o && $past(serial_data_out_oe_o, 3)
    && !chip_select_n_i && $changed(serial_data_out_o)
    |-> since_rise < 4'h8) else $error("out moved");
  a_int_pin_low: assert property (
    int_n_oe_o |-> !int_n_o) else $error("int level");
  a_int_disabled: assert property (
    !int_enable_i [*6] |-> !int_n_oe_o) else $error("int disabled");
  a_int_clear_cs: assert property (
    $fell(chip_select_n_i) |-> ##[1:8] !int_n_oe_o) else $error("int clr");
  a_int_has_cause: assert property (
    $rose(int_n_oe_o) |-> quiet < 4'ha) else $error("int cause");
  c_int_up: cover property ($rose(int_n_oe_o));
  c_int_down: cover property ($fell(int_n_oe_o));
  c_frame: cover property ($rose(serial_data_out_oe_o));
endmodule
bind ssi_shifter ssi_shifter_asserts #(.NUM_INPUTS(NUM_INPUTS)) chk (
  .clk_i(clk_i), .reset_i(reset_i), .switch_input_i(switch_input_i),
  .chip_select_n_i(chip_select_n_i), .serial_clock_i(serial_clock_i),
  .serial_data_in_i(serial_data_in_i), .serial_data_out_o(serial_data_out_o),
  .serial_data_out_oe_o(serial_data_out_oe_o), .int_enable_i(int_enable_i),
  .int_n_o(int_n_o), .int_n_oe_o(int_n_oe_o));

// [ssi_ctrl_model.sv]
/* serial controller model: frames msb first, 200 ns serial clock.
   assumes clk_i is the 40 MHz bench clock. */
`timescale 1ns/1ps
module ssi_ctrl_model (
  // clock
  input wire logic clk_i,
  // serial link
  output logic chip_select_n_o,
  output logic serial_clock_o,
  output logic serial_data_o,
  input wire logic serial_data_i
);
  initial begin
    chip_select_n_o = 1'b1;
    serial_clock_o = 1'b0;
    serial_data_o = 1'b0;
  end
  // =======================================
  // one frame; clock held low around chip select edges
  task automatic frame(input int nbits, input logic [31:0] tx,
                       output logic [31:0] rx);
    rx = '0;
    @(posedge clk_i);
    chip_select_n_o <= 1'b0;
    repeat (8) @(posedge clk_i);
    for (int i = nbits - 1; i >= 0; i--) begin
      serial_clock_o <= 1'b1;
      serial_data_o <= tx[i];
      repeat (4) @(posedge clk_i);
      serial_clock_o <= 1'b0;
      repeat (4) @(posedge clk_i);
      rx = {rx[30:0], serial_data_i};
    end
    repeat (4) @(posedge clk_i);
    chip_select_n_o <= 1'b1;
    serial_data_o <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask
  // serial clock and data wiggle while deselected; ends with clock low
  task automatic stray_clocks(input int n);
    for (int i = 0; i < n; i++) begin
      serial_clock_o <= 1'b1;
      serial_data_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      serial_clock_o <= 1'b0;
      serial_data_o <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
  endtask
endmodule

// [testbench.sv]
/* bench for ssi_shifter: controller model on the link, switches here.
   assumes the default wide variant. */
`timescale 1ns/1ps
module testbench
  import ssi_pkg::*;
();
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [15:0] sw = '0;
  logic int_en = 1'b1;
  logic cs_n, sclk, sdi, sdo, sdo_oe, int_n, int_oe;
  int n_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  wire sdo_line = sdo_oe ? sdo : ~sdo;
  wire int_line = int_oe ? int_n : 1'b1;
  always #12.5 clk_i = ~clk_i;
  ssi_shifter #(.NUM_INPUTS(SSI_WIDE_INPUTS)) DUT (
    .clk_i(clk_i), .reset_i(reset_i), .switch_input_i(sw),
    .chip_select_n_i(cs_n), .serial_clock_i(sclk),
    .serial_data_in_i(sdi), .serial_data_out_o(sdo),
    .serial_data_out_oe_o(sdo_oe), .int_enable_i(int_en),
    .int_n_o(int_n), .int_n_oe_o(int_oe));
  ssi_ctrl_model ctl (.clk_i(clk_i), .chip_select_n_o(cs_n),
    .serial_clock_o(sclk), .serial_data_o(sdi), .serial_data_i(sdo_line));
  // =======================================
  // checking and closing
  task automatic check(input string what, input logic [31:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  task automatic t_shift;
    logic [31:0] rx;
    sw <= 16'ha53c;
    repeat (10) @(posedge clk_i);
    check("oe idle", 1'b0, sdo_oe);
    ctl.frame(32, 32'h9234_5678, rx);
    check("frame", {16'ha53c, 16'h9234}, rx);
  endtask
  task automatic t_interrupt;
    logic [31:0] rx;
    sw <= 16'h00ff;
    repeat (12) @(posedge clk_i);
    check("int up", 1'b0, int_line);
    fork
      ctl.frame(16, '0, rx);
      begin
        repeat (20) @(posedge clk_i);
        check("int clear", 1'b1, int_line);
        sw <= 16'h0f0f;
      end
    join
    check("snapshot", 32'h0000_00ff, rx);
    check("int again", 1'b0, int_line);
    sw <= 16'h00ff;
    repeat (12) @(posedge clk_i);
    check("int match", 1'b1, int_line);
    sw <= 16'h8000;
    int_en <= 1'b0;
    repeat (12) @(posedge clk_i);
    check("int off", 1'b0, int_oe);
    int_en <= 1'b1;
    repeat (12) @(posedge clk_i);
    check("int on", 1'b0, int_line);
  endtask
  task automatic t_back_to_back;
    logic [31:0] rx;
    sw <= 16'hffff;
    repeat (4) @(posedge clk_i);
    ctl.frame(16, '0, rx);
    check("first", 32'h0000_ffff, rx);
    sw <= 16'h0001;
    ctl.stray_clocks(3);
    check("oe stray", 1'b0, sdo_oe);
    ctl.frame(16, '0, rx);
    check("second", 32'h0000_0001, rx);
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    t_shift();
    t_interrupt();
    t_back_to_back();
    tally_and_finish();
  end
endmodule
